// ===== inc/bdf_params.svh
`ifndef BDF_PARAMS_SVH
`define BDF_PARAMS_SVH
`define BDF_CLK_HZ 27'd125000000
`define BDF_ADDR_BRIGHT 8'h00
`define BDF_ADDR_CTRL 8'h01
`define BDF_ADDR_STATUS 8'h02
`define BDF_ADDR_FREQ 8'h03
`define BDF_ADDR_SHAPE 8'h04
`define BDF_ADDR_DITH 8'h05
`define BDF_RST_BYTE 8'h00
`define BDF_RST_FREQ 8'h01
`define BDF_SRC_EXT 2'b00
`define BDF_SRC_REG 2'b10
`define BDF_FLAG_OPEN 0
`define BDF_FLAG_SHORT 1
`define BDF_FLAG_UV 2
`define BDF_FLAG_OC 3
`define BDF_FLAG_OT 4
`define BDF_FREQ_UNIT 16'd1202
`define BDF_FREQ_LOW_HZ 16'd2402
`define BDF_BOOST_312K 2'b00
`define BDF_BOOST_1250K 2'b10
`define BDF_FULL_SCALE 32'd2048
`define BDF_CHANNELS 6
`endif

// ===== inc/bdf_pkg.sv
`default_nettype none
package bdf_pkg;
    typedef enum logic [1:0] {
        BDF_SHUT = 2'b00,
        BDF_IDLE = 2'b01,
        BDF_ACT = 2'b10
    } bdf_mode_type;
    typedef struct packed {
        logic enableIoSupplyPin;
        logic extDimIn;
        logic [5:0] lowCmp;
        logic [5:0] midCmp;
        logic [5:0] highCmp;
        logic belowLoThresh;
        logic belowHiThresh;
        logic overcurrentGuard;
        logic tempAbove150;
        logic tempBelow130;
        logic fsetFloatHigh;
        logic fsetShortGnd;
        logic [1:0] fsetBoostSel;
        logic [2:0] fsetDimSel;
    } bdf_pins_type;
endpackage : bdf_pkg
`default_nettype wire

// ===== rtl/bdf_core.sv
`include "bdf_params.svh"
`default_nettype none
module bdf_core #(
    parameter int RAMP_MS_CYCLES = 125000,
    parameter int HEADROOM_CYCLES = 1024,
    parameter int LEVEL_W = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // analog comparators and pins
    input wire bdf_pkg::bdf_pins_type pinsAsync,
    // register port
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // string and boost control
    output logic [5:0] channelOut,
    output logic boostEnable,
    output logic [1:0] boostFreqSel,
    output logic [LEVEL_W-1:0] boostLevelReq,
    output logic activeMode
);
    // three-stage pin synchroniser
    bdf_pkg::bdf_pins_type s1_ff, s2_ff, s3_ff, pin_ff;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            pin_ff <= '0;
        end else begin
            s1_ff <= pinsAsync;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                pin_ff <= s3_ff;
            end
        end
    end

    // registers
    logic [7:0] bright_ff, ctrl_ff, status_ff, freq_ff, shape_ff, dith_ff;
    bdf_pkg::bdf_mode_type mode_ff, nxt_mode;
    wire isAct = (mode_ff == bdf_pkg::BDF_ACT);
    wire onBit = ctrl_ff[0];
    wire [1:0] srcSel = ctrl_ff[2:1];
    wire freqFromResistorSel = freq_ff[4];
    wire [3:0] dimFrequencyCode = freq_ff[3:0];
    wire lowSupplyDetectEn = freq_ff[5];
    wire lowSupplyThresholdSel = freq_ff[6];
    wire [2:0] phaseShiftConfig = shape_ff[2:0];
    wire [2:0] slopeSel = shape_ff[5:3];
    wire [1:0] ditherSel = dith_ff[1:0];
    wire steadyDither = dith_ff[2];
    wire wrBright = regWrEn && regAddr == `BDF_ADDR_BRIGHT;
    wire wrCtrl = regWrEn && regAddr == `BDF_ADDR_CTRL;
    wire cfgOpen = !isAct;
    wire wrFreq = regWrEn && cfgOpen && regAddr == `BDF_ADDR_FREQ;
    wire wrShape = regWrEn && cfgOpen && regAddr == `BDF_ADDR_SHAPE;
    wire wrDith = regWrEn && cfgOpen && regAddr == `BDF_ADDR_DITH;
    wire rdStatus = regRdEn && regAddr == `BDF_ADDR_STATUS;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bright_ff <= `BDF_RST_BYTE;
            ctrl_ff <= `BDF_RST_BYTE;
            freq_ff <= `BDF_RST_FREQ;
            shape_ff <= `BDF_RST_BYTE;
            dith_ff <= `BDF_RST_BYTE;
        end else begin
            if (wrBright) bright_ff <= regWrData;
            if (wrCtrl) ctrl_ff <= regWrData;
            if (wrFreq) freq_ff <= regWrData;
            if (wrShape) shape_ff <= regWrData;
            if (wrDith) dith_ff <= regWrData;
        end
    end

    wire [7:0] rdMux = regAddr == `BDF_ADDR_BRIGHT ? bright_ff :
                       regAddr == `BDF_ADDR_CTRL ? ctrl_ff :
                       regAddr == `BDF_ADDR_STATUS ? status_ff :
                       regAddr == `BDF_ADDR_FREQ ? freq_ff :
                       regAddr == `BDF_ADDR_SHAPE ? shape_ff :
                       regAddr == `BDF_ADDR_DITH ? dith_ff : 8'h00;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) regRdData <= 8'h00;
        else if (regRdEn) regRdData <= rdMux;
    end

    // operating mode
    wire enPin = pin_ff.enableIoSupplyPin;
    wire wantOn = (srcSel == `BDF_SRC_EXT) ? pin_ff.extDimIn : onBit;
    always_comb begin
        nxt_mode = mode_ff;
        case (mode_ff)
            bdf_pkg::BDF_SHUT: if (enPin) nxt_mode = bdf_pkg::BDF_IDLE;
            bdf_pkg::BDF_IDLE: if (wantOn) nxt_mode = bdf_pkg::BDF_ACT;
            bdf_pkg::BDF_ACT: if (!wantOn) nxt_mode = bdf_pkg::BDF_IDLE;
            default: nxt_mode = bdf_pkg::BDF_SHUT;
        endcase
        if (!enPin) nxt_mode = bdf_pkg::BDF_SHUT;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) mode_ff <= bdf_pkg::BDF_SHUT;
        else mode_ff <= nxt_mode;
    end

    // protections
    logic otHold_ff;
    wire uvNow = lowSupplyDetectEn && (lowSupplyThresholdSel ?
                 pin_ff.belowHiThresh : pin_ff.belowLoThresh);
    wire ocNow = pin_ff.overcurrentGuard;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) otHold_ff <= 1'b0;
        else if (pin_ff.tempAbove150) otHold_ff <= 1'b1;
        else if (pin_ff.tempBelow130) otHold_ff <= 1'b0;
    end
    wire ledRun = isAct && !uvNow && !otHold_ff;
    wire boostRun = ledRun && !ocNow;

    // enabled strings and headroom loop
    wire [2:0] nStr = (phaseShiftConfig == 3'd0 || phaseShiftConfig == 3'd7) ?
                      3'd6 : phaseShiftConfig;
    wire staggered = phaseShiftConfig != 3'd0;
    logic [5:0] strEn;
    logic [5:0] strOpt;
    genvar g;
    generate
        for (g = 0; g < `BDF_CHANNELS; g++) begin : g_str
            assign strEn[g] = 3'(g) < nStr;
            assign strOpt[g] = strEn[g] && !pin_ff.lowCmp[g] &&
                               !pin_ff.midCmp[g] && !pin_ff.highCmp[g];
        end
    endgenerate
    wire anyLow = |(pin_ff.lowCmp & strEn);
    wire anyHigh = |(pin_ff.highCmp & strEn);
    wire anyOpt = |strOpt;
    wire lvlMax = &boostLevelReq;
    logic [31:0] hrCnt_ff;
    wire hrTick = hrCnt_ff == 32'(HEADROOM_CYCLES - 1);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hrCnt_ff <= '0;
            boostLevelReq <= '0;
        end else begin
            hrCnt_ff <= hrTick ? 32'd0 : hrCnt_ff + 32'd1;
            if (!boostRun) boostLevelReq <= '0;
            else if (hrTick && anyLow && !lvlMax)
                boostLevelReq <= boostLevelReq + 1'b1;
            else if (hrTick && !anyLow && anyHigh && !anyOpt &&
                     boostLevelReq != '0)
                boostLevelReq <= boostLevelReq - 1'b1;
        end
    end

    // fault flags, set wins over read clear
    logic [4:0] setF;
    assign setF[`BDF_FLAG_OPEN] = boostRun && anyLow && lvlMax;
    assign setF[`BDF_FLAG_SHORT] = ledRun && anyOpt && anyHigh;
    assign setF[`BDF_FLAG_UV] = isAct && enPin && uvNow;
    assign setF[`BDF_FLAG_OC] = isAct && ocNow;
    assign setF[`BDF_FLAG_OT] = otHold_ff;
    logic [7:0] clrF;
    always_comb begin
        clrF = rdStatus ? 8'hff : 8'h00;
        if (!enPin) clrF[`BDF_FLAG_UV] = 1'b1;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) status_ff <= `BDF_RST_BYTE;
        else status_ff <= (status_ff & ~clrF) | {3'b000, setF};
    end

    // dimming rate: hz and resolution
    logic [15:0] dimHz;
    logic [3:0] resBits;
    wire fsetFloat = pin_ff.fsetFloatHigh;
    wire directDim = pin_ff.fsetShortGnd && freqFromResistorSel;
    always_comb begin
        dimHz = `BDF_FREQ_UNIT * 16'd8;
        resBits = 4'd10;
        if (!freqFromResistorSel) begin
            if (dimFrequencyCode == 4'd0) begin
                dimHz = `BDF_FREQ_UNIT * 16'd4;
                resBits = 4'd11;
            end else if (dimFrequencyCode < 4'd5) begin
                dimHz = `BDF_FREQ_UNIT * (16'd4 + 16'(dimFrequencyCode));
                resBits = 4'd10;
            end else if (dimFrequencyCode < 4'd12) begin
                dimHz = `BDF_FREQ_UNIT * (16'd5 + 16'(dimFrequencyCode));
                resBits = 4'd9;
            end else begin
                dimHz = `BDF_FREQ_UNIT * (16'(dimFrequencyCode) * 16'd4 - 16'd28);
                resBits = 4'd8;
            end
        end else if (!fsetFloat) begin
            case (pin_ff.fsetDimSel)
                3'd0: begin dimHz = `BDF_FREQ_LOW_HZ; resBits = 4'd12; end
                3'd1: begin dimHz = `BDF_FREQ_UNIT * 16'd4; resBits = 4'd11; end
                3'd2: begin dimHz = `BDF_FREQ_UNIT * 16'd5; resBits = 4'd10; end
                3'd3: begin dimHz = `BDF_FREQ_UNIT * 16'd8; resBits = 4'd10; end
                3'd4: begin dimHz = `BDF_FREQ_UNIT * 16'd10; resBits = 4'd9; end
                3'd5: begin dimHz = `BDF_FREQ_UNIT * 16'd12; resBits = 4'd9; end
                3'd6: begin dimHz = `BDF_FREQ_UNIT * 16'd14; resBits = 4'd9; end
                default: begin dimHz = `BDF_FREQ_UNIT * 16'd16; resBits = 4'd9; end
            endcase
        end
    end
    wire [1:0] nxt_boostSel = (fsetFloat || pin_ff.fsetShortGnd) ?
                              `BDF_BOOST_1250K : pin_ff.fsetBoostSel;

    // tick generator at hz times 2^res, exact modulo accumulator
    logic [26:0] acc_ff;
    wire [26:0] stepHz = 27'(dimHz) << resBits;
    // one spare bit: the sum can pass 2^27 just before a wrap
    wire [27:0] accSum = 28'(acc_ff) + 28'(stepHz);
    wire dimTick = accSum >= 28'(`BDF_CLK_HZ);
    logic [11:0] cnt_ff;
    logic [2:0] perIdx_ff;
    wire [11:0] perMask = 12'((13'd1 << resBits) - 13'd1);
    wire perEnd = dimTick && cnt_ff == perMask;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_ff <= '0;
            cnt_ff <= '0;
            perIdx_ff <= '0;
        end else begin
            acc_ff <= dimTick ? 27'(accSum - 28'(`BDF_CLK_HZ)) : 27'(accSum);
            if (dimTick) cnt_ff <= (cnt_ff + 12'd1) & perMask;
            if (perEnd) perIdx_ff <= perIdx_ff + 3'd1;
        end
    end

    // brightness ramp in 8.3 fixed point
    logic [10:0] ramp_ff;
    logic [31:0] slCnt_ff;
    wire [10:0] target = {bright_ff, 3'b000};
    logic [31:0] slopeMs;
    always_comb begin
        case (slopeSel)
            3'd0: slopeMs = 32'd0;
            3'd1: slopeMs = 32'd50;
            3'd2: slopeMs = 32'd75;
            3'd3: slopeMs = 32'd100;
            3'd4: slopeMs = 32'd150;
            3'd5: slopeMs = 32'd200;
            3'd6: slopeMs = 32'd300;
            default: slopeMs = 32'd500;
        endcase
    end
    wire [31:0] stepCycles = slopeMs * 32'(RAMP_MS_CYCLES) / `BDF_FULL_SCALE;
    wire ramping = ramp_ff != target;
    wire slStep = slCnt_ff >= stepCycles;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ramp_ff <= '0;
            slCnt_ff <= '0;
        end else if (slopeMs == 32'd0) begin
            ramp_ff <= target;
            slCnt_ff <= '0;
        end else if (!ramping || slStep) begin
            slCnt_ff <= '0;
            if (ramping && ramp_ff < target) ramp_ff <= ramp_ff + 11'd1;
            else if (ramping) ramp_ff <= ramp_ff - 11'd1;
        end else begin
            slCnt_ff <= slCnt_ff + 32'd1;
        end
    end

    // duty with dither
    wire [22:0] dutyWide = 23'(ramp_ff) << resBits;
    wire [11:0] dutyInt = dutyWide[22:11];
    wire [2:0] dutyFrac = dutyWide[10:8];
    wire ditherOn = ditherSel != 2'd0 && (steadyDither || ramping);
    wire [2:0] fracMask = ditherSel == 2'd1 ? 3'b100 :
                          ditherSel == 2'd2 ? 3'b110 : 3'b111;
    wire [2:0] seqRev = {perIdx_ff[0], perIdx_ff[1], perIdx_ff[2]};
    wire stretch = ditherOn && (dutyFrac & fracMask) > seqRev;
    wire [12:0] dutyEff = 13'(dutyInt) + 13'(stretch);

    // per channel stagger and output
    wire [12:0] perLen = 13'(perMask) + 13'd1;
    wire extGate = srcSel == `BDF_SRC_REG ? 1'b1 : pin_ff.extDimIn;
    wire useReg = srcSel != `BDF_SRC_EXT;
    logic [5:0] nxt_ch;
    generate
        for (g = 0; g < `BDF_CHANNELS; g++) begin : g_ch
            wire [11:0] off = staggered ? 12'(16'(perLen) * 16'(g) / 16'd6) : 12'd0;
            wire [11:0] ph = (cnt_ff - off) & perMask;
            wire pwmOn = 13'(ph) < dutyEff;
            wire src = directDim ? pin_ff.extDimIn :
                       useReg ? (pwmOn && extGate) : pin_ff.extDimIn;
            assign nxt_ch[g] = ledRun && strEn[g] && src;
        end
    endgenerate
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            channelOut <= '0;
            boostEnable <= 1'b0;
            boostFreqSel <= `BDF_BOOST_312K;
            activeMode <= 1'b0;
        end else begin
            channelOut <= nxt_ch;
            boostEnable <= boostRun;
            boostFreqSel <= nxt_boostSel;
            activeMode <= isAct;
        end
    end

    // checks
    cfg_write_blocked_a: assert property (
        @(posedge clk) disable iff (!resetn)
        isAct && regWrEn && regAddr == `BDF_ADDR_SHAPE |=> $stable(shape_ff))
        else $error("config changed while active");
    open_flag_set_a: assert property (
        @(posedge clk) disable iff (!resetn)
        boostRun && anyLow && lvlMax |=> status_ff[`BDF_FLAG_OPEN])
        else $error("open flag missed");
    status_read_clr_a: assert property (
        @(posedge clk) disable iff (!resetn)
        rdStatus && setF == 5'd0 && enPin |=> status_ff == 8'h00)
        else $error("status not cleared by read");
    uv_pin_clear_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !enPin |=> !status_ff[`BDF_FLAG_UV])
        else $error("uv flag kept with pin low");
    oc_boost_off_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ocNow |=> !boostEnable)
        else $error("boost on during overcurrent");
    ot_outputs_off_a: assert property (
        @(posedge clk) disable iff (!resetn)
        otHold_ff |=> channelOut == 6'd0 && !boostEnable)
        else $error("outputs on during overtemp");
    shut_mode_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !enPin |=> !isAct ##1 !activeMode)
        else $error("active with enable pin low");
    level_rise_a: assert property (
        @(posedge clk) disable iff (!resetn)
        boostRun && hrTick && anyLow && !lvlMax ##1 boostRun
        |-> boostLevelReq == $past(boostLevelReq) + 1'b1)
        else $error("boost request did not rise");
    short_flag_set_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ledRun && anyOpt && anyHigh |=> status_ff[`BDF_FLAG_SHORT])
        else $error("short flag missed");
    uv_shutdown_a: assert property (
        @(posedge clk) disable iff (!resetn)
        uvNow |=> channelOut == 6'd0 ##0 !boostEnable)
        else $error("outputs on during undervoltage");
endmodule : bdf_core
`default_nettype wire

// ===== tb/bdf_string_model.sv
`default_nettype none
module bdf_string_model (
    // clock
    input wire logic clk,
    // scenario commands
    input wire logic [5:0] openMask,
    input wire logic [5:0] shortMask,
    // boost control
    input wire logic boostEnable,
    input wire logic [4:0] boostLevelReq,
    // headroom comparators
    output logic [5:0] lowCmp,
    output logic [5:0] midCmp,
    output logic [5:0] highCmp
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        lowCmp = 6'h3f;
        midCmp = 6'h00;
        highCmp = 6'h00;
    end
    // open string never gets headroom, shorted string needs none
    always @(negedge clk) begin
        for (int i = 0; i < 6; i++) begin
            lowCmp[i] <= openMask[i] || !boostEnable || (!shortMask[i] && boostLevelReq < 5'h04);
            midCmp[i] <= 1'b0;
            highCmp[i] <= !openMask[i] && boostEnable && (boostLevelReq >= (shortMask[i] ? 5'h03 : 5'h07));
        end
    end
endmodule : bdf_string_model
`default_nettype wire

// ===== tb/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    bdf_pkg::bdf_pins_type pinsTb;
    bdf_pkg::bdf_pins_type pins;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    logic [5:0] channelOut;
    logic boostEnable;
    logic [1:0] boostFreqSel;
    logic [4:0] boostLevelReq;
    logic activeMode;
    logic [5:0] openMask = 6'h00;
    logic [5:0] shortMask = 6'h00;
    logic [5:0] lowCmp;
    logic [5:0] midCmp;
    logic [5:0] highCmp;
    logic [7:0] rdVal;
    int per;
    int lag;
    int bad_count = 0;
    int checked = 0;
    always #4 clk = ~clk;
    always_comb begin
        pins = pinsTb;
        pins.lowCmp = lowCmp;
        pins.midCmp = midCmp;
        pins.highCmp = highCmp;
    end
    bdf_core #(.RAMP_MS_CYCLES(16), .HEADROOM_CYCLES(4), .LEVEL_W(5)) dut (.clk(clk), .resetn(resetn),
        .pinsAsync(pins), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .channelOut(channelOut), .boostEnable(boostEnable), .boostFreqSel(boostFreqSel),
        .boostLevelReq(boostLevelReq), .activeMode(activeMode));
    bdf_string_model strings (.clk(clk), .openMask(openMask), .shortMask(shortMask), .boostEnable(boostEnable),
        .boostLevelReq(boostLevelReq), .lowCmp(lowCmp), .midCmp(midCmp), .highCmp(highCmp));
    task automatic results();
        $display("mismatches %0d of %0d comparisons", bad_count, checked);
        if (bad_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        rdVal = regRdData;
    endtask : rd
    function automatic logic pick(input int s);
        case (s)
            0: return activeMode;
            1: return boostEnable;
            2: return boostLevelReq == 5'h1f;
            default: return channelOut[0];
        endcase
    endfunction : pick
    task automatic waitSig(input int s, input logic v, input int lim);
        int n;
        n = 0;
        while (pick(s) !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk({7'h00, pick(s)}, {7'h00, v});
        if (n >= lim) results();
    endtask : waitSig
    // cycles between two rises of string 0, and from string 0 rise to string 1 rise
    task automatic measure();
        int n;
        int r0;
        int r1;
        int r2;
        logic [5:0] prev;
        r0 = -1;
        r1 = -1;
        r2 = -1;
        prev = channelOut;
        for (n = 0; n < 10000 && r2 < 0; n++) begin
            @(negedge clk);
            if (channelOut[0] && !prev[0]) begin
                if (r0 < 0) r0 = n;
                else r2 = n;
            end
            if (channelOut[1] && !prev[1] && r0 >= 0 && r1 < 0) r1 = n;
            prev = channelOut;
        end
        per = r2 - r0;
        lag = r1 - r0;
    endtask : measure
    initial begin
        pinsTb = '0;
        pinsTb.tempBelow130 = 1'b1;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        chk({boostEnable, activeMode, channelOut}, 8'h00);
        rd(8'h02);
        chk(rdVal, 8'h00);
        rd(8'h03);
        chk(rdVal, 8'h01);
        pinsTb.enableIoSupplyPin = 1'b1;
        repeat (10) @(negedge clk);
        wr(8'h03, 8'h2f);
        wr(8'h04, 8'h07);
        wr(8'h77, 8'haa);
        rd(8'h03);
        chk(rdVal, 8'h2f);
        rd(8'h04);
        chk(rdVal, 8'h07);
        rd(8'h77);
        chk(rdVal, 8'h00);
        wr(8'h00, 8'h80);
        wr(8'h01, 8'h05);
        waitSig(0, 1'b1, 50);
        waitSig(1, 1'b1, 50);
        wr(8'h03, 8'h10);
        rd(8'h03);
        chk(rdVal, 8'h2f);
        wr(8'h04, 8'h38);
        rd(8'h04);
        chk(rdVal, 8'h07);
        measure();
        chk({7'h00, per inside {[(125000000 / 38464) - 2:(125000000 / 38464) + 2]}}, 8'h01);
        chk({7'h00, lag inside {[(per * (256 / 6)) / 256 - 3:(per * (256 / 6)) / 256 + 3]}}, 8'h01);
        rd(8'h02);
        openMask = 6'h01;
        waitSig(2, 1'b1, 400);
        repeat (20) @(negedge clk);
        openMask = 6'h00;
        repeat (20) @(negedge clk);
        rd(8'h02);
        chk(rdVal, 8'h01);
        rd(8'h02);
        chk(rdVal, 8'h00);
        shortMask = 6'h02;
        repeat (150) @(negedge clk);
        shortMask = 6'h00;
        repeat (20) @(negedge clk);
        rd(8'h02);
        chk(rdVal, 8'h02);
        pinsTb.belowHiThresh = 1'b1;
        repeat (20) @(negedge clk);
        chk({7'h00, boostEnable}, 8'h01);
        pinsTb.belowLoThresh = 1'b1;
        waitSig(1, 1'b0, 20);
        repeat (2) @(negedge clk);
        chk({2'b00, channelOut}, 8'h00);
        pinsTb.belowLoThresh = 1'b0;
        pinsTb.belowHiThresh = 1'b0;
        waitSig(1, 1'b1, 50);
        rd(8'h02);
        chk(rdVal, 8'h04);
        pinsTb.overcurrentGuard = 1'b1;
        waitSig(1, 1'b0, 20);
        pinsTb.overcurrentGuard = 1'b0;
        waitSig(1, 1'b1, 50);
        rd(8'h02);
        chk(rdVal, 8'h08);
        pinsTb.tempAbove150 = 1'b1;
        pinsTb.tempBelow130 = 1'b0;
        waitSig(1, 1'b0, 20);
        repeat (2) @(negedge clk);
        chk({2'b00, channelOut}, 8'h00);
        pinsTb.tempAbove150 = 1'b0;
        repeat (20) @(negedge clk);
        chk({7'h00, boostEnable}, 8'h00);
        pinsTb.tempBelow130 = 1'b1;
        waitSig(1, 1'b1, 50);
        rd(8'h02);
        chk(rdVal, 8'h10);
        wr(8'h01, 8'h00);
        waitSig(0, 1'b0, 20);
        wr(8'h03, 8'h30);
        pinsTb.fsetShortGnd = 1'b1;
        pinsTb.extDimIn = 1'b1;
        waitSig(0, 1'b1, 20);
        waitSig(3, 1'b1, 20);
        chk({6'h00, boostFreqSel}, 8'h02);
        pinsTb.extDimIn = 1'b0;
        waitSig(3, 1'b0, 20);
        pinsTb.extDimIn = 1'b1;
        pinsTb.fsetShortGnd = 1'b0;
        pinsTb.fsetBoostSel = 2'b01;
        repeat (10) @(negedge clk);
        chk({6'h00, boostFreqSel}, 8'h01);
        pinsTb.belowLoThresh = 1'b1;
        repeat (10) @(negedge clk);
        pinsTb.belowLoThresh = 1'b0;
        pinsTb.enableIoSupplyPin = 1'b0;
        waitSig(0, 1'b0, 20);
        chk({7'h00, boostEnable}, 8'h00);
        pinsTb.enableIoSupplyPin = 1'b1;
        repeat (10) @(negedge clk);
        rd(8'h02);
        chk(rdVal, 8'h00);
        results();
    end
endmodule : tb_top
`default_nettype wire
